// *** rtl/aidr_defs.svh ***
// Offsets, field positions, constant values and timing counts of the diagnostic record
`ifndef AIDR_DEFS_SVH
`define AIDR_DEFS_SVH

// ----------------------------------------------------------------------------
// Record numbers and lengths
// ----------------------------------------------------------------------------
`define AIDR_REC_SHORT 8'h00
`define AIDR_REC_FULL 8'h01
`define AIDR_LEN_SHORT 5'h04
`define AIDR_LEN_FULL 5'h14
`define AIDR_REC_BYTES 20
`define AIDR_IDX_W 5

// ----------------------------------------------------------------------------
// Byte offsets inside the record
// ----------------------------------------------------------------------------
`define AIDR_OFS_MODULE_FAULT_SUMMARY 5'h00
`define AIDR_OFS_MODULE_CLASS_INFO 5'h01
`define AIDR_OFS_SPARE_BYTE_TWO 5'h02
`define AIDR_OFS_EXTRA_FAULT_FLAGS 5'h03
`define AIDR_OFS_CHANNEL_KIND_CODE 5'h04
`define AIDR_OFS_DIAG_BITS_PER_CHANNEL 5'h05
`define AIDR_OFS_CHANNEL_COUNT 5'h06
`define AIDR_OFS_CHANNEL_GROUP_FAULT 5'h07
`define AIDR_OFS_INPUT0_FAULT 5'h08
`define AIDR_OFS_SPARE_INPUT_FAULTS 5'h0C
`define AIDR_OFS_DIAG_TIMESTAMP 5'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AIDR_SUM_MODULE_FAIL 0
`define AIDR_SUM_INTERNAL 1
`define AIDR_SUM_EXTERNAL 2
`define AIDR_SUM_CHANNEL 3
`define AIDR_SUM_PARAM 7
`define AIDR_EXT_INT_COMM 4
`define AIDR_EXT_PI_LOST 6
`define AIDR_CH_PARAM 0
`define AIDR_CH_WIRE_BREAK 4
`define AIDR_CH_PI_LOST 5
`define AIDR_CH_UNDERFLOW 6
`define AIDR_CH_OVERFLOW 7

// ----------------------------------------------------------------------------
// Constant contents
// ----------------------------------------------------------------------------
`define AIDR_CLASS_ANALOG 4'h5
`define AIDR_CLASS_CH_INFO 4
`define AIDR_KIND_ANALOG_IN 7'h71
`define AIDR_BITS_PER_CH 8'h08
`define AIDR_NUM_CH 8'h04
`define AIDR_RSVD_BYTE 8'h00

// ----------------------------------------------------------------------------
// Microsecond ticker timing
// ----------------------------------------------------------------------------
`define AIDR_TICK_NS 1000
`define AIDR_CLK_NS 10
`define AIDR_TICK_CYCLES (`AIDR_TICK_NS / `AIDR_CLK_NS)

`endif

// *** rtl/aidr_pkg.sv ***
// Types shared by the diagnostic record logic
package aidr_pkg;

    // Read sequencer states
    typedef enum logic [0:0] {
        AIDR_IDLE,
        AIDR_RUN
    } aidr_state_t;

    typedef logic [7:0] aidr_byte_t;

endpackage

// *** rtl/aidr_record_mem.sv ***
// Small byte memory holding the record image, registered read data
`timescale 1ns/1ps
`default_nettype none
`include "aidr_defs.svh"

module aidr_record_mem
    import aidr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic [`AIDR_IDX_W-1:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [`AIDR_IDX_W-1:0] rd_addr_i,
    output logic [7:0] rd_data_o
);

    aidr_byte_t mem [`AIDR_REC_BYTES];

    // ------------------------------------------------------------------------
    // Storage, cleared at reset so no unknown byte ever leaves
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < `AIDR_REC_BYTES; i++)
            begin
                mem[i] <= `AIDR_RSVD_BYTE;
            end
        end
        else if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // ------------------------------------------------------------------------
    // Registered read port
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rd_data_o <= `AIDR_RSVD_BYTE;
        end
        else
        begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule
`default_nettype wire

// *** rtl/aidr_diag_record.sv ***
// Diagnostic record of a four-channel analog input module, read by record number
`timescale 1ns/1ps
`default_nettype none
`include "aidr_defs.svh"

// Overview of operation
// - Record 01h returns the full record.
// - Record 00h returns the first four bytes.
// - Summary byte: bit0 failure, 1 internal, 2 external, 3 channel, 7 parameters.
// - Class byte carries 0101b analog in bits 3..0, bit4 channel info.
// - Byte 3: bit4 internal comms error, bit6 interrupt lost.
// - Bits per channel byte reads 08h.
// - Channel count byte reads 04h.
// - Group byte bit n set on an error in group n.
// - Channel byte bit0: parameterization error.
// - Channel bit4: wire break, thermometer or thermocouple inputs only.
// - Per-channel bit5 interrupt lost, bit6 underflow, bit7 overflow.
// - Last four bytes: ticker value at the event.
// - Microsecond ticker starts at zero, wraps at 32 bits.
// - Bytes of channels four to seven read 00h.
// - An error lights its channel LED and enters the record.
module aidr_diag_record
    import aidr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Record read port
    input wire logic rd_req_i,
    input wire logic [7:0] record_number_i,
    output logic rd_busy_o,
    output logic rd_reject_o,
    output logic byte_valid_o,
    output logic byte_last_o,
    output logic [7:0] byte_data_o,
    // Module level fault sources
    input wire logic module_fail_i,
    input wire logic internal_err_i,
    input wire logic external_err_i,
    input wire logic param_err_i,
    input wire logic int_comm_err_i,
    input wire logic pi_lost_i,
    // Per channel fault sources and input type flags
    input wire logic [3:0] ch_param_err_i,
    input wire logic [3:0] ch_wire_break_i,
    input wire logic [3:0] ch_pi_lost_i,
    input wire logic [3:0] ch_underflow_i,
    input wire logic [3:0] ch_overflow_i,
    input wire logic [3:0] resistance_thermometer_input_i,
    input wire logic [3:0] thermocouple_input_i,
    // Channel indicator LEDs
    output logic [3:0] channel_led_o
);

    localparam int SYNC_W = 34;
    localparam int TICK_W = 7;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(`AIDR_TICK_CYCLES - 1);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_in;
    logic s_module_fail;
    logic s_internal;
    logic s_external;
    logic s_param;
    logic s_int_comm;
    logic s_pi_lost;
    logic [3:0] s_ch_param;
    logic [3:0] s_ch_wire;
    logic [3:0] s_ch_pi_lost;
    logic [3:0] s_ch_under;
    logic [3:0] s_ch_over;
    logic [3:0] s_rtd;
    logic [3:0] s_tc;
    aidr_byte_t input_fault [4];
    aidr_byte_t module_fault_summary;
    aidr_byte_t module_class_info;
    aidr_byte_t extra_fault_flags;
    aidr_byte_t channel_kind_code;
    aidr_byte_t channel_group_fault;
    aidr_byte_t rec_img [`AIDR_REC_BYTES];
    logic [63:0] fault_vec;
    logic [63:0] fault_prev;
    logic diag_event;
    logic [TICK_W-1:0] tick_div;
    logic [31:0] us_ticker;
    logic [31:0] diag_timestamp;
    aidr_state_t state;
    logic [`AIDR_IDX_W-1:0] rd_idx;
    logic [`AIDR_IDX_W-1:0] rd_len;
    logic [`AIDR_IDX_W-1:0] refresh_idx;
    logic issue_last;
    logic req_ok;
    logic refresh_en;

    // ------------------------------------------------------------------------
    // Record length decode, zero for an unknown record number
    // ------------------------------------------------------------------------
    function automatic logic [`AIDR_IDX_W-1:0] record_len(input logic [7:0] num);
        logic [`AIDR_IDX_W-1:0] len;
        len = '0;
        if (num == `AIDR_REC_FULL)
        begin
            len = `AIDR_LEN_FULL;
        end
        else if (num == `AIDR_REC_SHORT)
        begin
            len = `AIDR_LEN_SHORT;
        end
        return len;
    endfunction

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // Fault sources are asynchronous
    assign raw_in = {module_fail_i, internal_err_i, external_err_i, param_err_i,
                     int_comm_err_i, pi_lost_i, ch_param_err_i, ch_wire_break_i,
                     ch_pi_lost_i, ch_underflow_i, ch_overflow_i,
                     resistance_thermometer_input_i, thermocouple_input_i};

    // Two flops per bit
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++)
        begin : gen_sync
            always_ff @(posedge clk_sys_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                begin
                    sync_meta[g] <= 1'b0;
                    sync_in[g] <= 1'b0;
                end
                else
                begin
                    sync_meta[g] <= raw_in[g];
                    sync_in[g] <= sync_meta[g];
                end
            end
        end
    endgenerate

    // Split into named sources
    assign {s_module_fail, s_internal, s_external, s_param, s_int_comm, s_pi_lost,
            s_ch_param, s_ch_wire, s_ch_pi_lost, s_ch_under, s_ch_over,
            s_rtd, s_tc} = sync_in;

    // ------------------------------------------------------------------------
    // Fault byte assembly
    // ------------------------------------------------------------------------
    // One fault byte per channel
    generate
        for (g = 0; g < 4; g++)
        begin : gen_chan
            always_comb
            begin
                input_fault[g] = `AIDR_RSVD_BYTE;
                input_fault[g][`AIDR_CH_PARAM] = s_ch_param[g];
                input_fault[g][`AIDR_CH_WIRE_BREAK] = s_ch_wire[g] & (s_rtd[g] | s_tc[g]);
                input_fault[g][`AIDR_CH_PI_LOST] = s_ch_pi_lost[g];
                input_fault[g][`AIDR_CH_UNDERFLOW] = s_ch_under[g];
                input_fault[g][`AIDR_CH_OVERFLOW] = s_ch_over[g];
            end
            // Group n is channel n on this four-channel module
            assign channel_group_fault[g] = |input_fault[g];
        end
    endgenerate

    // Upper half of the group byte is reserved
    assign channel_group_fault[7:4] = 4'h0;

    // Module summary byte
    always_comb
    begin
        module_fault_summary = `AIDR_RSVD_BYTE;
        module_fault_summary[`AIDR_SUM_MODULE_FAIL] = s_module_fail;
        module_fault_summary[`AIDR_SUM_INTERNAL] = s_internal;
        module_fault_summary[`AIDR_SUM_EXTERNAL] = s_external;
        module_fault_summary[`AIDR_SUM_CHANNEL] = |channel_group_fault;
        module_fault_summary[`AIDR_SUM_PARAM] = s_param;
    end

    // Extra flags byte, all other bits reserved
    always_comb
    begin
        extra_fault_flags = `AIDR_RSVD_BYTE;
        extra_fault_flags[`AIDR_EXT_INT_COMM] = s_int_comm;
        extra_fault_flags[`AIDR_EXT_PI_LOST] = s_pi_lost;
    end

    // Fixed identification bytes
    always_comb
    begin
        module_class_info = `AIDR_RSVD_BYTE;
        module_class_info[3:0] = `AIDR_CLASS_ANALOG;
        module_class_info[`AIDR_CLASS_CH_INFO] = 1'b1;
        channel_kind_code = {1'b0, `AIDR_KIND_ANALOG_IN};
    end

    // LED per channel follows that channel's fault byte
    assign channel_led_o = channel_group_fault[3:0];

    // ------------------------------------------------------------------------
    // Record image, byte by byte in record order
    // ------------------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < `AIDR_REC_BYTES; i++)
        begin
            rec_img[i] = `AIDR_RSVD_BYTE;
        end
        rec_img[`AIDR_OFS_MODULE_FAULT_SUMMARY] = module_fault_summary;
        rec_img[`AIDR_OFS_MODULE_CLASS_INFO] = module_class_info;
        rec_img[`AIDR_OFS_SPARE_BYTE_TWO] = `AIDR_RSVD_BYTE;
        rec_img[`AIDR_OFS_EXTRA_FAULT_FLAGS] = extra_fault_flags;
        rec_img[`AIDR_OFS_CHANNEL_KIND_CODE] = channel_kind_code;
        rec_img[`AIDR_OFS_DIAG_BITS_PER_CHANNEL] = `AIDR_BITS_PER_CH;
        rec_img[`AIDR_OFS_CHANNEL_COUNT] = `AIDR_NUM_CH;
        rec_img[`AIDR_OFS_CHANNEL_GROUP_FAULT] = channel_group_fault;
        for (int i = 0; i < 4; i++)
        begin
            rec_img[`AIDR_OFS_INPUT0_FAULT + i] = input_fault[i];
        end
        // Little endian timestamp closes the record
        for (int i = 0; i < 4; i++)
        begin
            rec_img[`AIDR_OFS_DIAG_TIMESTAMP + i] = diag_timestamp[8*i +: 8];
        end
    end

    // ------------------------------------------------------------------------
    // Microsecond ticker
    // ------------------------------------------------------------------------
    // One tick per microsecond
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tick_div <= '0;
        end
        else if (tick_div == TICK_LAST)
        begin
            tick_div <= '0;
        end
        else
        begin
            tick_div <= tick_div + 1'b1;
        end
    end

    // Free running count, wraps naturally at its width
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            us_ticker <= 32'h0000_0000;
        end
        else if (tick_div == TICK_LAST)
        begin
            us_ticker <= us_ticker + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------------
    // Diagnostic event capture
    // ------------------------------------------------------------------------
    // Only a newly raised fault bit counts; clearing does not re-stamp
    assign fault_vec = {module_fault_summary, extra_fault_flags, channel_group_fault,
                        `AIDR_RSVD_BYTE, input_fault[0], input_fault[1],
                        input_fault[2], input_fault[3]};
    assign diag_event = |(fault_vec & ~fault_prev);

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            fault_prev <= '0;
        end
        else
        begin
            fault_prev <= fault_vec;
        end
    end

    // Stamp of the last new fault
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            diag_timestamp <= 32'h0000_0000;
        end
        else if (diag_event)
        begin
            diag_timestamp <= us_ticker;
        end
    end

    // ------------------------------------------------------------------------
    // Record image refresh
    // ------------------------------------------------------------------------
    // Refresh pauses during a read so the host sees one coherent snapshot
    assign refresh_en = (state == AIDR_IDLE) && !byte_valid_o;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            refresh_idx <= '0;
        end
        else if (refresh_en)
        begin
            if (refresh_idx == `AIDR_LEN_FULL - 1'b1)
            begin
                refresh_idx <= '0;
            end
            else
            begin
                refresh_idx <= refresh_idx + 1'b1;
            end
        end
    end

    aidr_record_mem u_mem (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(refresh_en),
        .wr_addr_i(refresh_idx),
        .wr_data_i(rec_img[refresh_idx]),
        .rd_addr_i(rd_idx),
        .rd_data_o(byte_data_o)
    );

    // ------------------------------------------------------------------------
    // Read sequencer
    // ------------------------------------------------------------------------
    assign req_ok = rd_req_i && !rd_busy_o && (record_len(record_number_i) != '0);
    assign issue_last = (rd_idx == rd_len - 1'b1);
    assign rd_busy_o = (state != AIDR_IDLE) || byte_valid_o;

    // Walk the byte index over the requested length
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= AIDR_IDLE;
            rd_idx <= '0;
            rd_len <= '0;
        end
        else
        begin
            case (state)
                AIDR_IDLE:
                begin
                    rd_idx <= '0;
                    if (req_ok)
                    begin
                        rd_len <= record_len(record_number_i);
                        state <= AIDR_RUN;
                    end
                end
                AIDR_RUN:
                begin
                    if (issue_last)
                    begin
                        state <= AIDR_IDLE;
                        rd_idx <= '0;
                    end
                    else
                    begin
                        rd_idx <= rd_idx + 1'b1;
                    end
                end
                default:
                begin
                    state <= AIDR_IDLE;
                end
            endcase
        end
    end

    // Byte strobes trail the index by the memory's read register
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            byte_valid_o <= 1'b0;
            byte_last_o <= 1'b0;
        end
        else
        begin
            byte_valid_o <= (state == AIDR_RUN);
            byte_last_o <= (state == AIDR_RUN) && issue_last;
        end
    end

    // Unknown numbers: one-cycle refusal
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rd_reject_o <= 1'b0;
        end
        else
        begin
            rd_reject_o <= rd_req_i && !rd_busy_o && (record_len(record_number_i) == '0);
        end
    end

endmodule
`default_nettype wire

// *** testbench/aidr_diag_record_asserts.sv ***
// Assertion checker for the diagnostic record read port
`timescale 1ns/1ps
`default_nettype none
module aidr_diag_record_asserts
    import aidr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic rd_req_i,
    input wire logic [7:0] record_number_i,
    input wire logic rd_busy_o,
    input wire logic rd_reject_o,
    input wire logic byte_valid_o,
    input wire logic byte_last_o,
    input wire logic [7:0] byte_data_o,
    input wire logic [3:0] ch_overflow_i,
    input wire logic [3:0] channel_led_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    logic take;
    logic [4:0] idx;
    // Taken request
    assign take = rd_req_i && !rd_busy_o;
    // Byte position on the port
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            idx <= 5'h00;
        else
            idx <= (byte_valid_o && !byte_last_o) ? idx + 5'h01 : 5'h00;
    end
    full_first_a: assert property (take && record_number_i == 8'h01 |-> ##2 byte_valid_o && idx == 5'h00)
        else $error("full record start late");
    full_last_a: assert property (take && record_number_i == 8'h01 |-> ##21 byte_last_o && idx == 5'h13)
        else $error("full record length wrong");
    short_len_a: assert property (take && record_number_i == 8'h00 |-> ##5 byte_last_o && idx == 5'h03)
        else $error("short record length wrong");
    bad_reject_a: assert property (take && record_number_i > 8'h01 |=> rd_reject_o ##1 !byte_valid_o)
        else $error("bad number not refused");
    last_free_a: assert property (byte_last_o |=> !byte_valid_o && !rd_busy_o)
        else $error("busy after last byte");
    class_byte_a: assert property (byte_valid_o && idx == 5'h01 |-> byte_data_o == 8'h15 ##1 byte_data_o == 8'h00)
        else $error("class or spare byte");
    kind_count_a: assert property (byte_valid_o && idx == 5'h04 |-> byte_data_o == 8'h71 ##1 byte_data_o == 8'h08
        ##1 byte_data_o == 8'h04)
        else $error("kind or count byte wrong");
    spare_inputs_a: assert property (byte_valid_o && idx == 5'h0C |-> (byte_data_o == 8'h00) [*4])
        else $error("spare inputs not zero");
    rsvd_bits_a: assert property (byte_valid_o && idx == 5'h00 |-> byte_data_o[6:4] == 3'b000
        ##3 (byte_data_o & 8'hAF) == 8'h00)
        else $error("reserved bits set");
    group_sum_a: assert property (byte_valid_o && idx == 5'h07 |-> byte_data_o[7:4] == 4'h0
        && $past(byte_data_o[3], 7) == (byte_data_o != 8'h00))
        else $error("summary vs group byte");
    led_track_a: assert property ((reset_n_i && $stable(ch_overflow_i)) [*3]
        |-> (channel_led_o & ch_overflow_i) == ch_overflow_i)
        else $error("LED dark on fault");
    cover property (take && record_number_i == 8'h01);
    cover property (take && record_number_i == 8'h00);
    cover property (rd_reject_o);
endmodule
bind aidr_diag_record aidr_diag_record_asserts i_aidr_diag_record_asserts (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .rd_req_i(rd_req_i), .record_number_i(record_number_i), .rd_busy_o(rd_busy_o),
    .rd_reject_o(rd_reject_o), .byte_valid_o(byte_valid_o), .byte_last_o(byte_last_o),
    .byte_data_o(byte_data_o), .ch_overflow_i(ch_overflow_i), .channel_led_o(channel_led_o));
`default_nettype wire

// *** testbench/aidr_host_model.sv ***
// Host model that asks the record port for one record at a time
`timescale 1ns/1ps
`default_nettype none
module aidr_host_model
    import aidr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic go_i,
    input wire logic [7:0] num_i,
    input wire logic rd_busy_i,
    output logic rd_req_o,
    output logic [7:0] record_number_o
);
    logic pend;
    // Waits for an idle port; idle number toggles
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pend <= 1'b0;
            rd_req_o <= 1'b0;
            record_number_o <= 8'h00;
        end
        else if (pend && !rd_busy_i && !rd_req_o)
        begin
            pend <= 1'b0;
            rd_req_o <= 1'b1;
            record_number_o <= num_i;
        end
        else
        begin
            pend <= pend | go_i;
            rd_req_o <= 1'b0;
            record_number_o <= ~record_number_o;
        end
    end
endmodule
`default_nettype wire

// *** testbench/tb_aidr_diag_record.sv ***
// Self-checking bench for the diagnostic record read port
`timescale 1ns/1ps
`default_nettype none
module tb_aidr_diag_record
    import aidr_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic go = 1'b0;
    logic tb_req = 1'b0;
    logic [7:0] num = 8'h00;
    logic host_req;
    logic [7:0] host_num;
    logic rd_busy_o, rd_reject_o, byte_valid_o, byte_last_o;
    logic [7:0] byte_data_o;
    logic [3:0] channel_led_o;
    logic [5:0] mf = 6'h00; // Fail, internal, external, param, comm, lost
    logic [3:0] cp = 4'h0, cw = 4'h0, cl = 4'h0, cu = 4'h0, co = 4'h0, rt = 4'h0, tc = 4'h0;
    logic [31:0] seed = 32'h176c_65d1;
    logic [31:0] ts = 32'h0000_0000;
    int cyc = 0;
    int n_errors = 0;
    int total_checks = 0;
    logic [9:0] exp_q[$];
    aidr_byte_t rec[20];
    // Reset gates requests
    aidr_diag_record i_aidr_diag_record (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .rd_req_i(reset_n_i & (host_req | tb_req)), .record_number_i({8{reset_n_i}} & (tb_req ? 8'h00 : host_num)),
        .rd_busy_o(rd_busy_o), .rd_reject_o(rd_reject_o), .byte_valid_o(byte_valid_o), .byte_last_o(byte_last_o),
        .byte_data_o(byte_data_o), .module_fail_i(mf[0]), .internal_err_i(mf[1]), .external_err_i(mf[2]),
        .param_err_i(mf[3]), .int_comm_err_i(mf[4]), .pi_lost_i(mf[5]), .ch_param_err_i(cp), .ch_wire_break_i(cw),
        .ch_pi_lost_i(cl), .ch_underflow_i(cu), .ch_overflow_i(co), .resistance_thermometer_input_i(rt),
        .thermocouple_input_i(tc), .channel_led_o(channel_led_o));
    aidr_host_model i_aidr_host_model (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .go_i(go), .num_i(num),
        .rd_busy_i(rd_busy_o), .rd_req_o(host_req), .record_number_o(host_num));
    // Clock; cycles since reset predict the ticker
    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i or negedge reset_n_i)
    begin
        cyc <= reset_n_i ? cyc + 1 : 0;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic check(input string what, input logic [9:0] e, input logic [9:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // Expected record image
    function automatic void build();
        aidr_byte_t ch[4];
        for (int i = 0; i < 4; i++)
            ch[i] = {co[i], cu[i], cl[i], cw[i] & (rt[i] | tc[i]), 3'b000, cp[i]};
        rec[7] = {4'h0, |ch[3], |ch[2], |ch[1], |ch[0]};
        rec[0] = {mf[3], 3'b000, |rec[7], mf[2:0]};
        rec[1] = 8'h15;
        rec[2] = 8'h00;
        rec[3] = {1'b0, mf[5], 1'b0, mf[4], 4'h0};
        rec[4] = 8'h71;
        rec[5] = 8'h08;
        rec[6] = 8'h04;
        for (int i = 0; i < 4; i++)
        begin
            rec[8 + i] = ch[i];
            rec[12 + i] = 8'h00;
            rec[16 + i] = ts[8 * i +: 8];
        end
    endfunction
    // Faults change mid-tick so the stamp is unambiguous
    task automatic apply(input logic [33:0] v);
        logic [55:0] old;
        build();
        old = {rec[0], rec[3], rec[7], rec[8], rec[9], rec[10], rec[11]};
        do @(posedge clk_sys_i); while (cyc % 100 != 20);
        {mf, cp, cw, cl, cu, co, rt, tc} <= v;
        #1 build();
        if (|({rec[0], rec[3], rec[7], rec[8], rec[9], rec[10], rec[11]} & ~old))
            ts = (cyc - 1) / 100;
        repeat (40) @(posedge clk_sys_i);
        check("channel led", {6'h00, rec[11] != 0, rec[10] != 0, rec[9] != 0, rec[8] != 0}, {6'h00, channel_led_o});
    endtask
    // Notes expected bytes, asks the host; inj adds a busy request
    task automatic read(input logic [7:0] n, input int len, input bit inj);
        int k;
        build();
        for (int i = 0; i < len; i++)
            exp_q.push_back({1'b0, i == len - 1, rec[i]});
        if (len == 0)
            exp_q.push_back(10'h200);
        @(posedge clk_sys_i);
        go <= 1'b1;
        num <= n;
        @(posedge clk_sys_i);
        go <= 1'b0;
        if (inj)
        begin
            repeat (5) @(posedge clk_sys_i);
            tb_req <= 1'b1;
            @(posedge clk_sys_i);
            tb_req <= 1'b0;
        end
        k = 0;
        while (exp_q.size() != 0 && k < 100)
        begin
            @(posedge clk_sys_i);
            k++;
        end
        check("queue drained", 10'h000, {9'h000, exp_q.size() != 0});
        exp_q.delete();
    endtask
    // Pairs each result with the oldest note
    always @(posedge clk_sys_i)
    begin
        if (byte_valid_o === 1'b1 || rd_reject_o === 1'b1)
            check("record byte", exp_q.size() ? exp_q.pop_front() : 10'h3ff,
                {rd_reject_o, byte_last_o, rd_reject_o ? 8'h00 : byte_data_o});
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog far past the run
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        end_of_test();
    end
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        read(8'h01, 20, 1'b0);
        read(8'h01, 20, 1'b1);
        read(8'h00, 4, 1'b0);
        read(8'h02, 0, 1'b0);
        read(8'hFF, 0, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            apply({seed[1:0], xs(seed)});
            read(8'h01, 20, 1'b0);
            read(8'h00, 4, 1'b0);
        end
        @(posedge clk_sys_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        ts = 32'h0000_0000;
        repeat (40) @(posedge clk_sys_i);
        read(8'h01, 20, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
